// ===== hkas_cfg.svh
// Register offsets, field positions and reset values of the converter sequencer
`ifndef HKAS_CFG_SVH
`define HKAS_CFG_SVH
`define HKAS_TEMP_RESULT_ADDR 8'hD7
`define HKAS_START_ADDR 8'hD8
`define HKAS_BATT_RESULT_ADDR 8'hDF
`define HKAS_PWR_ENABLE_ADDR 8'hEC
`define HKAS_VOLT_RESULT_ADDR 8'hEF
`define HKAS_THRESH_ADDR 8'hF3
`define HKAS_PWR_FLAGS_ADDR 8'hF8
`define HKAS_INTERVAL_ADDR 8'hF9
`define HKAS_LOWBAT_ADDR 8'hFA
`define HKAS_BATT_GO_BIT 0
`define HKAS_TEMP_GO_BIT 1
`define HKAS_VOLT_GO_BIT 2
`define HKAS_LOWBAT_BIT 2
`define HKAS_VOLT_FLAG_BIT 3
`define HKAS_TEMP_DELTA_MSB 5
`define HKAS_TEMP_DELTA_LSB 3
`define HKAS_VOLT_DELTA_MSB 2
`define HKAS_VOLT_DELTA_LSB 0
`define HKAS_TEMP_IVL_MSB 1
`define HKAS_TEMP_IVL_LSB 0
`define HKAS_BATT_IVL_MSB 3
`define HKAS_BATT_IVL_LSB 2
`define HKAS_VOLT_IVL_MSB 5
`define HKAS_VOLT_IVL_LSB 4
`define HKAS_RESET_BYTE 8'h00
`define HKAS_DELTA_OFF 3'h0
`define HKAS_DELTA_ALL 3'h7
`endif

// ===== hkas_pkg.sv
// Types shared by the converter sequencer
package hkas_pkg;
	typedef enum logic [2:0] {
		HKAS_FULL = 3'h1,
		HKAS_BATTERY = 3'h2,
		HKAS_SLEEP = 3'h4
	} hkas_mode_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hkas_sfr_req_t;
	typedef struct packed {
		logic [2:0] req;
		logic [2:0] single;
	} hkas_conv_req_t;
	typedef struct packed {
		logic [2:0] done;
		logic [7:0] temp;
		logic [7:0] batt;
		logic [7:0] volt;
	} hkas_conv_res_t;
endpackage

// ===== hkas_delta_check.sv
// Change detector: compares a new result with the last reported one
`timescale 1ns/10ps
`include "hkas_cfg.svh"
module hkas_delta_check (
	input wire logic [7:0] new_value,
	input wire logic [7:0] last_value,
	input wire logic [2:0] delta_code,
	output logic exceeds
);
	logic [7:0] diff;
	always_comb begin
		diff = (new_value > last_value) ? new_value - last_value : last_value - new_value;
		// Code 0 never reports, code 7 reports all, else strictly greater
		if (delta_code == `HKAS_DELTA_OFF) begin
			exceeds = 1'b0;
		end else if (delta_code == `HKAS_DELTA_ALL) begin
			exceeds = 1'b1;
		end else begin
			exceeds = diff > {5'h00, delta_code};
		end
	end
endmodule

// ===== hkas_sequencer.sv
// Housekeeping converter sequencer: starts, background strobes, results, flags
//
// Summary of operation
// - No background temperature conversions until a nonzero temperature interval is written.
// - Temperature interrupt when result differs from last reported by more than delta.
// - Temperature: full mode both kinds, battery single only, sleep background only.
// - Temperature result register loads only when the temperature interrupt fires.
// - Single temperature conversion completion always raises the flagless temperature interrupt.
// - Battery start bit launches one conversion; result stored and low-battery flag set.
// - Background battery result below threshold sets the low-battery flag.
// - Low-battery flag requests power interrupt only while its enable is set.
// - Battery: full mode both kinds, battery single only, sleep none.
// - Single battery completion sets low-battery flag; result loads only when that flag is set.
// - Voltage start bit launches one conversion; result stored and interrupt signalled.
// - No background voltage conversions until a nonzero voltage interval is written.
// - Voltage change beyond delta sets the external-voltage flag.
// - External-voltage flag requests power interrupt only while its enable is set.
// - Voltage: full mode both kinds, battery single only, sleep background only.
// - Voltage result changes only on the voltage interrupt, delta or single completion.
// - Each start bit clears itself once the converter accepts the request.
// - Delta code 0 disables, 1 to 6 are LSB thresholds, 7 reports all.
`timescale 1ns/10ps
`include "hkas_cfg.svh"
module hkas_sequencer (
	input wire logic clk,
	input wire logic rst_n,
	input wire hkas_pkg::hkas_sfr_req_t sfr_req,
	input wire hkas_pkg::hkas_mode_t power_mode,
	input wire logic [2:0] interval_tick,
	input wire logic [2:0] conv_ack,
	input wire hkas_pkg::hkas_conv_res_t conv_res,
	output logic [7:0] sfr_rdata,
	output hkas_pkg::hkas_conv_req_t conv_req,
	output logic temp_irq,
	output logic volt_irq,
	output logic power_irq
);
	import hkas_pkg::*;

	// ==========================================================
	// Registers
	logic [7:0] start_reg;
	logic [7:0] enable_reg;
	logic [7:0] thresh_reg;
	logic [7:0] flags_reg;
	logic [7:0] interval_reg;
	logic [7:0] lowbat_reg;
	logic [7:0] temp_result_reg;
	logic [7:0] batt_result_reg;
	logic [7:0] volt_result_reg;
	logic [7:0] temp_last_reg;
	logic [7:0] volt_last_reg;
	logic [2:0] single_pend_reg;
	logic [2:0] bg_pend_reg;
	logic [2:0] busy_reg;
	logic [2:0] busy_single_reg;
	hkas_conv_req_t conv_req_reg;
	logic temp_irq_reg;
	logic volt_irq_reg;
	logic power_irq_reg;
	logic [7:0] rdata_reg;

	logic [2:0] go_bits;
	logic [2:0] bg_enabled;
	logic [2:0] single_allowed;
	logic [2:0] bg_allowed;
	logic [2:0] issue;
	logic temp_change;
	logic volt_change;
	logic temp_fire;
	logic volt_fire;
	logic batt_set;
	logic volt_set;
	logic start_wr;
	logic flags_wr;

	assign go_bits = {start_reg[`HKAS_VOLT_GO_BIT], start_reg[`HKAS_TEMP_GO_BIT],
		start_reg[`HKAS_BATT_GO_BIT]};
	// Zero interval field means background off, which is also the reset state
	assign bg_enabled = {
		|interval_reg[`HKAS_VOLT_IVL_MSB:`HKAS_VOLT_IVL_LSB],
		|interval_reg[`HKAS_TEMP_IVL_MSB:`HKAS_TEMP_IVL_LSB],
		|interval_reg[`HKAS_BATT_IVL_MSB:`HKAS_BATT_IVL_LSB]};
	// Bit order: 2 voltage, 1 temperature, 0 battery
	always_comb begin
		unique case (power_mode)
			HKAS_FULL: begin
				single_allowed = 3'h7;
				bg_allowed = 3'h7;
			end
			HKAS_BATTERY: begin
				single_allowed = 3'h7;
				bg_allowed = 3'h0;
			end
			HKAS_SLEEP: begin
				single_allowed = 3'h0;
				bg_allowed = 3'h6;
			end
			default: begin
				single_allowed = 3'h0;
				bg_allowed = 3'h0;
			end
		endcase
	end
	assign start_wr = sfr_req.wr && sfr_req.addr == `HKAS_START_ADDR;
	assign flags_wr = sfr_req.wr && sfr_req.addr == `HKAS_PWR_FLAGS_ADDR;

	// ==========================================================
	// Software registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= `HKAS_RESET_BYTE;
			thresh_reg <= `HKAS_RESET_BYTE;
			interval_reg <= `HKAS_RESET_BYTE;
			lowbat_reg <= `HKAS_RESET_BYTE;
		end else if (sfr_req.wr) begin
			unique case (sfr_req.addr)
				`HKAS_PWR_ENABLE_ADDR: enable_reg <= sfr_req.wdata;
				`HKAS_THRESH_ADDR: thresh_reg <= sfr_req.wdata;
				`HKAS_INTERVAL_ADDR: interval_reg <= sfr_req.wdata;
				`HKAS_LOWBAT_ADDR: lowbat_reg <= sfr_req.wdata;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Start bits: cleared on acceptance, acceptance beats a new write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_reg <= `HKAS_RESET_BYTE;
		end else begin
			if (start_wr) begin
				start_reg[7:3] <= {sfr_req.wdata[7] | start_reg[7], 4'h0};
			end
			for (int i = 0; i < 3; i++) begin
				if (conv_req_reg.req[i] && conv_req_reg.single[i] && conv_ack[i]) begin
					start_reg[i] <= 1'b0;
				end else if (start_wr) begin
					start_reg[i] <= sfr_req.wdata[i] | start_reg[i];
				end
			end
		end
	end

	// ==========================================================
	// Request issue: one outstanding conversion per channel
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_ch
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					bg_pend_reg[g] <= 1'b0;
					single_pend_reg[g] <= 1'b0;
				end else begin
					if (interval_tick[g] && bg_enabled[g] && bg_allowed[g]) begin
						bg_pend_reg[g] <= 1'b1;
					end else if (issue[g] && !(single_pend_reg[g] && single_allowed[g])) begin
						bg_pend_reg[g] <= 1'b0;
					end
					single_pend_reg[g] <= go_bits[g] && single_allowed[g];
				end
			end
			// Mode is checked again at issue, so a strobe pended earlier waits out a forbidden mode
			assign issue[g] = !busy_reg[g] && !conv_req_reg.req[g] &&
				((bg_pend_reg[g] && bg_allowed[g]) ||
				(single_pend_reg[g] && single_allowed[g]));
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					conv_req_reg.req[g] <= 1'b0;
					conv_req_reg.single[g] <= 1'b0;
					busy_reg[g] <= 1'b0;
					busy_single_reg[g] <= 1'b0;
				end else begin
					if (issue[g]) begin
						conv_req_reg.req[g] <= 1'b1;
						conv_req_reg.single[g] <= single_pend_reg[g] && single_allowed[g];
					end else if (conv_req_reg.req[g] && conv_ack[g]) begin
						conv_req_reg.req[g] <= 1'b0;
						busy_reg[g] <= 1'b1;
						busy_single_reg[g] <= conv_req_reg.single[g];
					end else if (conv_res.done[g]) begin
						busy_reg[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Completion handling
	hkas_delta_check u_temp_delta (
		.new_value(conv_res.temp),
		.last_value(temp_last_reg),
		.delta_code(thresh_reg[`HKAS_TEMP_DELTA_MSB:`HKAS_TEMP_DELTA_LSB]),
		.exceeds(temp_change)
	);
	hkas_delta_check u_volt_delta (
		.new_value(conv_res.volt),
		.last_value(volt_last_reg),
		.delta_code(thresh_reg[`HKAS_VOLT_DELTA_MSB:`HKAS_VOLT_DELTA_LSB]),
		.exceeds(volt_change)
	);
	assign temp_fire = busy_reg[1] && conv_res.done[1] &&
		(busy_single_reg[1] || temp_change);
	assign volt_fire = busy_reg[2] && conv_res.done[2] &&
		(busy_single_reg[2] || volt_change);
	assign batt_set = busy_reg[0] && conv_res.done[0] &&
		(busy_single_reg[0] || conv_res.batt < lowbat_reg);
	assign volt_set = volt_fire;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_result_reg <= `HKAS_RESET_BYTE;
			temp_last_reg <= `HKAS_RESET_BYTE;
		end else if (temp_fire) begin
			temp_result_reg <= conv_res.temp;
			temp_last_reg <= conv_res.temp;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			volt_result_reg <= `HKAS_RESET_BYTE;
			volt_last_reg <= `HKAS_RESET_BYTE;
		end else if (volt_fire) begin
			volt_result_reg <= conv_res.volt;
			volt_last_reg <= conv_res.volt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			batt_result_reg <= `HKAS_RESET_BYTE;
		end else if (batt_set) begin
			batt_result_reg <= conv_res.batt;
		end
	end

	// Flags: write one to clear, a new event in the same cycle wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_reg <= `HKAS_RESET_BYTE;
		end else begin
			if (flags_wr) begin
				flags_reg <= flags_reg & ~sfr_req.wdata;
			end
			if (batt_set) begin
				flags_reg[`HKAS_LOWBAT_BIT] <= 1'b1;
			end
			if (volt_set) begin
				flags_reg[`HKAS_VOLT_FLAG_BIT] <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Interrupt outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_irq_reg <= 1'b0;
			volt_irq_reg <= 1'b0;
			power_irq_reg <= 1'b0;
		end else begin
			temp_irq_reg <= temp_fire;
			volt_irq_reg <= volt_fire;
			power_irq_reg <= (flags_reg[`HKAS_LOWBAT_BIT] && enable_reg[`HKAS_LOWBAT_BIT]) ||
				(flags_reg[`HKAS_VOLT_FLAG_BIT] && enable_reg[`HKAS_VOLT_FLAG_BIT]);
		end
	end

	// ==========================================================
	// Read port, registered one cycle after the read strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= `HKAS_RESET_BYTE;
		end else if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				`HKAS_TEMP_RESULT_ADDR: rdata_reg <= temp_result_reg;
				`HKAS_START_ADDR: rdata_reg <= start_reg;
				`HKAS_BATT_RESULT_ADDR: rdata_reg <= batt_result_reg;
				`HKAS_PWR_ENABLE_ADDR: rdata_reg <= enable_reg;
				`HKAS_VOLT_RESULT_ADDR: rdata_reg <= volt_result_reg;
				`HKAS_THRESH_ADDR: rdata_reg <= thresh_reg;
				`HKAS_PWR_FLAGS_ADDR: rdata_reg <= flags_reg;
				`HKAS_INTERVAL_ADDR: rdata_reg <= interval_reg;
				`HKAS_LOWBAT_ADDR: rdata_reg <= lowbat_reg;
				default: rdata_reg <= `HKAS_RESET_BYTE;
			endcase
		end
	end

	assign sfr_rdata = rdata_reg;
	assign conv_req = conv_req_reg;
	assign temp_irq = temp_irq_reg;
	assign volt_irq = volt_irq_reg;
	assign power_irq = power_irq_reg;

	// ==========================================================
	// Assertions
	temp_result_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!temp_fire |=> $stable(temp_result_reg))
		else $error("temperature result changed without interrupt");
	temp_irq_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		temp_fire |=> temp_irq && temp_result_reg == $past(conv_res.temp))
		else $error("temperature interrupt or result missing");
	single_temp_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
		busy_reg[1] && busy_single_reg[1] && conv_res.done[1] |=> temp_irq)
		else $error("single temperature completion without interrupt");
	no_bg_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		interval_reg[`HKAS_TEMP_IVL_MSB:`HKAS_TEMP_IVL_LSB] == 2'h0 && !bg_pend_reg[1]
		|=> !bg_pend_reg[1])
		else $error("background temperature without interval");
	no_bg_volt_a: assert property (@(posedge clk) disable iff (!rst_n)
		interval_reg[`HKAS_VOLT_IVL_MSB:`HKAS_VOLT_IVL_LSB] == 2'h0 && !bg_pend_reg[2]
		|=> !bg_pend_reg[2])
		else $error("background voltage without interval");
	volt_result_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!volt_fire |=> $stable(volt_result_reg))
		else $error("voltage result changed without interrupt");
	power_irq_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		flags_reg[`HKAS_LOWBAT_BIT] && enable_reg[`HKAS_LOWBAT_BIT] |=> power_irq)
		else $error("enabled low battery flag without power interrupt");
	batt_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		batt_set |=> flags_reg[`HKAS_LOWBAT_BIT] && batt_result_reg == $past(conv_res.batt))
		else $error("low battery flag or result not set");
	batt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!batt_set |=> $stable(batt_result_reg))
		else $error("battery result changed without flag");
	power_irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		!enable_reg[`HKAS_LOWBAT_BIT] && !enable_reg[`HKAS_VOLT_FLAG_BIT] |=> !power_irq)
		else $error("power interrupt without enable");
	volt_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		volt_set |=> flags_reg[`HKAS_VOLT_FLAG_BIT] && volt_last_reg == $past(conv_res.volt))
		else $error("voltage flag not set");
	sleep_no_batt_a: assert property (@(posedge clk) disable iff (!rst_n)
		power_mode == HKAS_SLEEP && !conv_req_reg.req[0] |=> !conv_req_reg.req[0])
		else $error("battery request in sleep");
	start_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		conv_req_reg.req[2] && conv_req_reg.single[2] && conv_ack[2] |=> !start_reg[2])
		else $error("voltage start bit not cleared");
	single_cov_c: cover property (@(posedge clk) disable iff (!rst_n) temp_fire && busy_single_reg[1]);
	bg_change_c: cover property (@(posedge clk) disable iff (!rst_n) volt_fire && !busy_single_reg[2]);
	lowbat_c: cover property (@(posedge clk) disable iff (!rst_n) batt_set ##2 power_irq);
	sleep_bg_c: cover property (@(posedge clk) disable iff (!rst_n) power_mode == HKAS_SLEEP && temp_fire);
endmodule

// ===== hkas_conv_model.sv
// Behavioural model of the three housekeeping converters
`timescale 1ns/10ps
module hkas_conv_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire hkas_pkg::hkas_conv_req_t conv_req,
	input wire logic [3:0] ack_wait,
	input wire logic [3:0] conv_wait,
	input wire logic [2:0][7:0] sample,
	output logic [2:0] conv_ack,
	output hkas_pkg::hkas_conv_res_t conv_res
);
	import hkas_pkg::*;
	// ====================
	// Per channel: idle, accepting, converting
	logic [1:0] phase [3];
	logic [3:0] cnt [3];
	logic [7:0] held [3];
	logic [2:0][7:0] val;
	logic [2:0] done;
	logic [7:0] noise;
	// Results toggle outside the done pulse, so a stale value is never taken
	assign conv_res = {done, val[1], val[0], val[2]};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			noise <= 8'h00;
			conv_ack <= 3'h0;
			done <= 3'h0;
			val <= '0;
			for (int i = 0; i < 3; i++) begin
				phase[i] <= 2'h0;
				cnt[i] <= 4'h0;
				held[i] <= 8'h00;
			end
		end else begin
			noise <= noise + 8'h35;
			for (int i = 0; i < 3; i++) begin
				conv_ack[i] <= 1'b0;
				done[i] <= 1'b0;
				val[i] <= ~noise ^ 8'(i);
				case (phase[i])
					2'h0: if (conv_req.req[i]) begin
						phase[i] <= 2'h1;
						cnt[i] <= ack_wait;
					end
					2'h1: if (cnt[i] != 4'h0) begin
						cnt[i] <= cnt[i] - 4'h1;
					end else begin
						conv_ack[i] <= 1'b1;
						phase[i] <= 2'h2;
						cnt[i] <= conv_wait;
						held[i] <= sample[i];
					end
					default: if (cnt[i] != 4'h0) begin
						cnt[i] <= cnt[i] - 4'h1;
					end else begin
						done[i] <= 1'b1;
						val[i] <= held[i];
						phase[i] <= 2'h0;
					end
				endcase
			end
		end
	end
endmodule

// ===== hkas_sequencer_bench.sv
// Self-checking bench of the housekeeping converter sequencer
`timescale 1ns/10ps
`include "hkas_cfg.svh"
module hkas_sequencer_bench;
	import hkas_pkg::*;
	localparam hkas_mode_t MODES [3] = '{HKAS_FULL, HKAS_BATTERY, HKAS_SLEEP};
	localparam logic [7:0] RES [3] = '{8'hDF, 8'hD7, 8'hEF};
	localparam logic [7:0] REGS [10] = '{8'hD7, 8'hD8, 8'hDF, 8'hEC, 8'hEF, 8'hF3, 8'hF8,
		8'hF9, 8'hFA, 8'h80};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	hkas_sfr_req_t sfr_req = '0;
	hkas_mode_t power_mode = HKAS_FULL;
	logic [2:0] interval_tick = 3'h0;
	logic [2:0] conv_ack;
	hkas_conv_res_t conv_res;
	logic [7:0] sfr_rdata;
	hkas_conv_req_t conv_req;
	logic temp_irq;
	logic volt_irq;
	logic power_irq;
	logic [3:0] ack_wait = 4'h0;
	logic [3:0] conv_wait = 4'h0;
	logic [2:0][7:0] sample = '0;
	int fail_count = 0;
	int checks_done = 0;
	int ch;
	logic [7:0] last [3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0] rdv, v;
	logic [7:0] dcode = 8'h00;
	logic [7:0] ivl = 8'h00;
	logic [7:0] thr = 8'h00;
	logic [7:0] en = 8'h00;
	logic irq_seen, ran;
	always #20 clk = ~clk;
	hkas_sequencer u_hkas_sequencer (.clk(clk), .rst_n(rst_n), .sfr_req(sfr_req),
		.power_mode(power_mode), .interval_tick(interval_tick), .conv_ack(conv_ack),
		.conv_res(conv_res), .sfr_rdata(sfr_rdata), .conv_req(conv_req),
		.temp_irq(temp_irq), .volt_irq(volt_irq), .power_irq(power_irq));
	hkas_conv_model u_hkas_conv_model (.clk(clk), .rst_n(rst_n), .conv_req(conv_req),
		.ack_wait(ack_wait), .conv_wait(conv_wait), .sample(sample), .conv_ack(conv_ack),
		.conv_res(conv_res));
	// ====================
	// Helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		sfr_req.wr = 1'b0;
	endtask
	task automatic sfr_read(input logic [7:0] a);
		@(negedge clk);
		sfr_req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		sfr_req.rd = 1'b0;
		@(negedge clk);
		rdv = sfr_rdata;
	endtask
	function automatic logic exceeds(input logic [7:0] a, input logic [7:0] b,
		input logic [2:0] c);
		logic [7:0] d;
		d = (a > b) ? a - b : b - a;
		return (c == 3'h7) || (c != 3'h0 && d > {5'h00, c});
	endfunction
	function automatic logic [1:0] fld(input int c);
		return c == 0 ? ivl[3:2] : (c == 1 ? ivl[1:0] : ivl[5:4]);
	endfunction
	// One conversion, single or background, then every visible effect
	task automatic convert(input int c, input logic [7:0] x, input logic single,
		input hkas_mode_t m);
		logic go;
		logic sgl;
		logic rep;
		logic [7:0] fb;
		go = single ? (m != HKAS_SLEEP)
			: (m == HKAS_FULL || (m == HKAS_SLEEP && c != 0)) && fld(c) != 2'h0;
		sample[c] = x;
		ack_wait = 4'($urandom);
		conv_wait = 4'($urandom);
		if (single) begin
			sfr_write(`HKAS_START_ADDR, 8'(8'h01 << c));
			power_mode = m;
		end else begin
			power_mode = m;
			interval_tick[c] = 1'b1;
			@(negedge clk);
			interval_tick = 3'h0;
		end
		irq_seen = 1'b0;
		ran = 1'b0;
		sgl = single;
		for (int i = 0; i < 80; i++) begin
			@(negedge clk);
			ran |= conv_res.done[c];
			if (conv_req.req[c]) sgl = conv_req.single[c];
			irq_seen |= (c == 1) ? temp_irq : (c == 2) & volt_irq;
			if (i == 30 && single && m == HKAS_SLEEP) begin
				check(ran, 1'b0);
				power_mode = HKAS_FULL;
				go = 1'b1;
			end
		end
		power_mode = HKAS_FULL;
		check(ran, go);
		check(sgl, single);
		rep = go && (single || (c == 0 ? x < thr
			: exceeds(x, last[c], c == 1 ? dcode[5:3] : dcode[2:0])));
		fb = (rep && c != 1) ? (c == 0 ? 8'h04 : 8'h08) : 8'h00;
		if (c != 0) check(irq_seen, rep);
		if (rep) last[c] = x;
		sfr_read(RES[c]);
		check(rdv, last[c]);
		sfr_read(`HKAS_PWR_FLAGS_ADDR);
		check(rdv & 8'h0C, fb);
		check(power_irq, |(fb & en));
		sfr_read(`HKAS_START_ADDR);
		check(rdv, 8'h00);
		sfr_write(`HKAS_PWR_FLAGS_ADDR, 8'h0C);
		sfr_read(`HKAS_PWR_FLAGS_ADDR);
		check(rdv & 8'h0C, 8'h00);
	endtask
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ====================
	// Tests
	initial begin
		void'($urandom(10907));
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		foreach (REGS[i]) begin
			sfr_read(REGS[i]);
			check(rdv, 8'h00);
		end
		sfr_write(`HKAS_TEMP_RESULT_ADDR, 8'h5A);
		sfr_read(`HKAS_TEMP_RESULT_ADDR);
		check(rdv, 8'h00);
		$display("test reset_values done");
		for (int c = 0; c < 3; c++) convert(c, 8'hA5, 1'b0, HKAS_FULL);
		convert(1, 8'h40, 1'b1, HKAS_FULL);
		convert(2, 8'h80, 1'b1, HKAS_FULL);
		convert(0, 8'h10, 1'b1, HKAS_BATTERY);
		dcode = 8'h38;
		sfr_write(`HKAS_THRESH_ADDR, dcode);
		thr = 8'h20;
		sfr_write(`HKAS_LOWBAT_ADDR, thr);
		ivl = 8'h3F;
		sfr_write(`HKAS_INTERVAL_ADDR, ivl);
		en = 8'h0C;
		sfr_write(`HKAS_PWR_ENABLE_ADDR, en);
		sfr_read(`HKAS_THRESH_ADDR);
		check(rdv, dcode);
		sfr_read(`HKAS_LOWBAT_ADDR);
		check(rdv, thr);
		convert(1, 8'h40, 1'b0, HKAS_FULL);
		convert(2, 8'h00, 1'b0, HKAS_FULL);
		convert(0, 8'h1F, 1'b0, HKAS_FULL);
		convert(0, 8'h20, 1'b0, HKAS_FULL);
		convert(1, 8'h41, 1'b1, HKAS_SLEEP);
		convert(0, 8'h00, 1'b0, HKAS_SLEEP);
		$display("test corner_cases done");
		for (int n = 0; n < 48; n++) begin
			ch = int'($urandom % 3);
			if (n % 6 == 0) begin
				dcode = 8'($urandom) & 8'h3F;
				ivl = 8'($urandom) & 8'h3F;
				en = 8'($urandom) & 8'h0C;
				sfr_write(`HKAS_THRESH_ADDR, dcode);
				sfr_write(`HKAS_INTERVAL_ADDR, ivl);
				sfr_write(`HKAS_PWR_ENABLE_ADDR, en);
				sfr_read(`HKAS_INTERVAL_ADDR);
				check(rdv, ivl);
			end
			v = 8'($urandom);
			if (n % 4 == 1) v = last[ch] + {5'h00, ch == 1 ? dcode[5:3] : dcode[2:0]};
			convert(ch, v, 1'($urandom), MODES[$urandom % 3]);
		end
		$display("test random_conversions done");
		end_sim();
	end
	// Generous bound, about eight times the expected run
	initial begin
		#2000000;
		fail_count++;
		end_sim();
	end
endmodule
